/* File: psr_regs.svh */
`ifndef PSR_REGS_SVH
`define PSR_REGS_SVH

`define PSR_CTRL_OFS      4'h0
`define PSR_STAT_OFS      4'h4
`define PSR_MASK_OFS      4'h8
`define PSR_STATE_OFS     4'hC

`define PSR_CTRL_W        6
`define PSR_CTRL_RST      6'h00
`define PSR_C_DET_EN      0
`define PSR_C_DET_FALL    1
`define PSR_C_DET_RISE    2
`define PSR_C_REG_LP      3
`define PSR_C_MODE_LO     4
`define PSR_C_MODE_HI     5

`define PSR_STAT_W        5
`define PSR_STAT_RST      5'h00
`define PSR_MASK_RST      5'h00
`define PSR_S_DET_FALL    0
`define PSR_S_DET_RISE    1
`define PSR_S_STOP_WK     2
`define PSR_S_SLEEP_WK    3
`define PSR_S_STBY        4

`define PSR_CLK_NS        10
`define PSR_RST_HOLD_NS   20000
`define PSR_RST_HOLD_CYC  ((`PSR_RST_HOLD_NS + `PSR_CLK_NS - 1) / `PSR_CLK_NS)
`define PSR_RST_CW        12
`define PSR_MIN_SUPPLY_MV 2000
`endif

/* File: psr_pkg.sv */
package psr_pkg;
    typedef enum logic [2:0] {
        PSR_RESET = 3'b000,
        PSR_RUN   = 3'b001,
        PSR_SLEEP = 3'b010,
        PSR_STOP  = 3'b011,
        PSR_STBY  = 3'b100
    } psr_state_t;

    typedef enum logic [1:0] {
        PSR_LP_SLEEP = 2'b00,
        PSR_LP_STOP  = 2'b01,
        PSR_LP_STBY  = 2'b10
    } psr_lp_t;
endpackage

/* File: psr_sync.sv */
`timescale 1ns/1ps
module psr_sync import psr_pkg::*; #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    // Levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

/* File: psr_rst_seq.sv */
`timescale 1ns/1ps
`include "psr_regs.svh"
module psr_rst_seq import psr_pkg::*; (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rstn,
    // Sequence
    input  wire logic hold,
    output logic      done
);
    localparam logic [`PSR_RST_CW-1:0] HOLD_CYC =
        `PSR_RST_CW'(`PSR_RST_HOLD_CYC);

    logic [`PSR_RST_CW-1:0] cnt_q;
    logic [`PSR_RST_CW-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (hold) begin
            cnt_d = '0;
        end else if (cnt_q != HOLD_CYC) begin
            cnt_d = cnt_q + `PSR_RST_CW'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign done = !hold && (cnt_q == HOLD_CYC);
endmodule

/* File: psr_top.sv */
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "psr_regs.svh"
module psr_top import psr_pkg::*; (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Supply comparators and option
    input  wire logic        main_supply_ok,
    input  wire logic        analog_supply_ok,
    input  wire logic        analog_sup_off,
    input  wire logic        detector_above,
    // Pins
    input  wire logic        external_reset_pin_n,
    input  wire logic        wakeup_pin,
    input  wire logic [15:0] ext_lines,
    // On-chip sources
    input  wire logic        independent_watchdog_rst,
    input  wire logic        rtc_event,
    input  wire logic        first_two_wire_port_evt,
    input  wire logic        first_serial_port_evt,
    input  wire logic        periph_event,
    input  wire logic        cpu_lp_req,
    // Power and clock controls
    output logic             core_rst_n,
    output logic             cpu_clk_en,
    output logic             core_clk_en,
    output logic             pll_en,
    output logic             internal_rc_oscillator_en,
    output logic             external_crystal_oscillator_en,
    output logic             regulator_on,
    output logic             regulator_lowpwr,
    output logic             retain_en,
    output logic             irq
);
    function automatic logic sel(input logic [3:0] a, input logic [3:0] o);
        sel = (a[3:2] == o[3:2]);
    endfunction

    // Pin synchronisers
    logic [20:0] pins_s;
    logic [15:0] ext_s;
    logic        wake_s;
    logic        xrst_n_s;
    logic        det_s;
    logic        ana_ok_s;
    logic        main_ok_s;

    psr_sync #(.W(21)) u_sync (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .async_in ({ext_lines, wakeup_pin, external_reset_pin_n,
                    detector_above, analog_supply_ok, main_supply_ok}),
        .sync_out (pins_s)
    );
    assign {ext_s, wake_s, xrst_n_s, det_s, ana_ok_s, main_ok_s} = pins_s;

    // State
    psr_state_t              state_q;
    psr_state_t              state_d;
    logic [`PSR_CTRL_W-1:0]  ctrl_q;
    logic [`PSR_CTRL_W-1:0]  ctrl_d;
    logic [`PSR_STAT_W-1:0]  stat_q;
    logic [`PSR_STAT_W-1:0]  stat_d;
    logic [`PSR_STAT_W-1:0]  mask_q;
    logic [`PSR_STAT_W-1:0]  mask_d;
    logic                    reg_lp_q;
    logic                    reg_lp_d;
    logic                    det_prev_q;
    logic                    wake_prev_q;
    logic [15:0]             ext_prev_q;
    logic                    ack_q;
    logic                    ack_d;
    logic [31:0]             rdata_q;
    logic [31:0]             rdata_d;

    // Supply monitors
    logic por_hold;
    logic pdr_hold;
    logic sup_hold;
    logic rst_src;
    logic seq_done;

    assign por_hold = !main_ok_s;
    assign pdr_hold = !main_ok_s || (!ana_ok_s && !analog_sup_off);
    // Evaluated in every state, standby included
    assign sup_hold = por_hold || pdr_hold;
    assign rst_src  = sup_hold || !xrst_n_s || independent_watchdog_rst;

    psr_rst_seq u_seq (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .hold    (rst_src || (state_q != PSR_RESET)),
        .done    (seq_done)
    );

    // Events
    logic det_fall;
    logic det_rise;
    logic det_evt;
    logic wake_rise;
    logic stop_wake;
    logic sleep_wake;
    logic stby_wake;

    assign det_fall  = ctrl_q[`PSR_C_DET_EN] && det_prev_q && !det_s;
    assign det_rise  = ctrl_q[`PSR_C_DET_EN] && !det_prev_q && det_s;
    assign det_evt   = det_fall || det_rise;
    assign wake_rise = wake_s && !wake_prev_q;
    assign stop_wake = |(ext_s & ~ext_prev_q) || det_evt || rtc_event
                       || first_two_wire_port_evt
                       || first_serial_port_evt;
    assign sleep_wake = periph_event || stop_wake;
    assign stby_wake  = rst_src || wake_rise || rtc_event;

    // Power state machine
    always_comb begin
        state_d  = state_q;
        reg_lp_d = reg_lp_q;
        unique case (state_q)
            PSR_RESET: begin
                if (seq_done) begin
                    state_d = PSR_RUN;
                end
            end
            PSR_RUN: begin
                if (cpu_lp_req) begin
                    case (psr_lp_t'(ctrl_q[`PSR_C_MODE_HI:`PSR_C_MODE_LO]))
                        PSR_LP_STOP: begin
                            state_d  = PSR_STOP;
                            reg_lp_d = ctrl_q[`PSR_C_REG_LP];
                        end
                        PSR_LP_STBY: begin
                            state_d = PSR_STBY;
                        end
                        default: begin
                            state_d = PSR_SLEEP;
                        end
                    endcase
                end
            end
            PSR_SLEEP: begin
                if (sleep_wake) begin
                    state_d = PSR_RUN;
                end
            end
            PSR_STOP: begin
                if (stop_wake) begin
                    state_d = PSR_RUN;
                end
            end
            PSR_STBY: begin
                if (stby_wake) begin
                    state_d = PSR_RESET;
                end
            end
            default: begin
                state_d = PSR_RESET;
            end
        endcase
        if (rst_src) begin
            state_d = PSR_RESET;
        end
    end

    // Avalon slave, one wait state per access
    logic req;
    logic wr_fire;

    assign req     = avs_read || avs_write;
    assign wr_fire = avs_write && ack_q;

    always_comb begin
        ack_d   = req && !ack_q;
        rdata_d = rdata_q;
        if (avs_read && !ack_q) begin
            rdata_d = 32'h0000_0000;
            if (sel(avs_address, `PSR_CTRL_OFS)) begin
                rdata_d = {26'h0, ctrl_q};
            end else if (sel(avs_address, `PSR_STAT_OFS)) begin
                rdata_d = {27'h0, stat_q};
            end else if (sel(avs_address, `PSR_MASK_OFS)) begin
                rdata_d = {27'h0, mask_q};
            end else begin
                rdata_d = {27'h0, analog_sup_off, det_s, state_q};
            end
        end
    end

    // Registers, lost outside the standby circuitry
    logic [`PSR_STAT_W-1:0] set_v;
    logic [`PSR_STAT_W-1:0] clr_v;

    always_comb begin
        set_v = '0;
        set_v[`PSR_S_DET_FALL] = det_fall && ctrl_q[`PSR_C_DET_FALL];
        set_v[`PSR_S_DET_RISE] = det_rise && ctrl_q[`PSR_C_DET_RISE];
        set_v[`PSR_S_STOP_WK]  = (state_q == PSR_STOP) && stop_wake;
        set_v[`PSR_S_SLEEP_WK] = (state_q == PSR_SLEEP) && sleep_wake;
        set_v[`PSR_S_STBY]     = (state_q == PSR_STBY) && stby_wake
                                 && !sup_hold;
        clr_v = '0;
        if (wr_fire && sel(avs_address, `PSR_STAT_OFS)) begin
            clr_v = avs_writedata[`PSR_STAT_W-1:0];
        end
        // Set wins over a same-cycle clear
        stat_d = (stat_q & ~clr_v) | set_v;
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        if (wr_fire && sel(avs_address, `PSR_CTRL_OFS)) begin
            ctrl_d = avs_writedata[`PSR_CTRL_W-1:0];
        end
        if (wr_fire && sel(avs_address, `PSR_MASK_OFS)) begin
            mask_d = avs_writedata[`PSR_STAT_W-1:0];
        end
        if (state_q == PSR_RESET || state_q == PSR_STBY) begin
            // Core domain unpowered or in reset
            ctrl_d = `PSR_CTRL_RST;
            mask_d = `PSR_MASK_RST;
            stat_d = (stat_q & (`PSR_STAT_W'(1) << `PSR_S_STBY)) | set_v;
        end
        if (sup_hold) begin
            stat_d[`PSR_S_STBY] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q     <= PSR_RESET;
            ctrl_q      <= `PSR_CTRL_RST;
            stat_q      <= `PSR_STAT_RST;
            mask_q      <= `PSR_MASK_RST;
            reg_lp_q    <= 1'b0;
            det_prev_q  <= 1'b0;
            wake_prev_q <= 1'b0;
            ext_prev_q  <= 16'h0000;
            ack_q       <= 1'b0;
            rdata_q     <= 32'h0000_0000;
        end else begin
            state_q     <= state_d;
            ctrl_q      <= ctrl_d;
            stat_q      <= stat_d;
            mask_q      <= mask_d;
            reg_lp_q    <= reg_lp_d;
            det_prev_q  <= det_s;
            wake_prev_q <= wake_s;
            ext_prev_q  <= ext_s;
            ack_q       <= ack_d;
            rdata_q     <= rdata_d;
        end
    end

    // Outputs
    logic off_clk;

    assign off_clk = (state_q == PSR_STOP) || (state_q == PSR_STBY);
    assign avs_waitrequest  = req && !ack_q;
    assign avs_readdata     = rdata_q;
    assign core_rst_n       = (state_q == PSR_RUN) || (state_q == PSR_SLEEP)
                              || (state_q == PSR_STOP);
    assign cpu_clk_en       = (state_q == PSR_RUN);
    assign core_clk_en      = !off_clk;
    assign pll_en           = !off_clk;
    assign internal_rc_oscillator_en      = !off_clk;
    assign external_crystal_oscillator_en = !off_clk;
    assign regulator_on     = (state_q != PSR_STBY);
    assign regulator_lowpwr = (state_q == PSR_STOP) && reg_lp_q;
    assign retain_en        = (state_q == PSR_STOP);
    assign irq              = |(stat_q & mask_q);

    // Checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_monitor_in_stby: assert property (
        state_q == PSR_STBY && sup_hold |=> state_q == PSR_RESET)
        else $error("Supply loss in standby did not reset");
    a_hold_while_low: assert property (
        sup_hold |=> !core_rst_n ##1 !core_rst_n)
        else $error("Core left reset with a low supply");
    a_por_ignores_ana: assert property (
        state_q == PSR_RUN && !ana_ok_s && analog_sup_off && !rst_src
        && !cpu_lp_req |=> state_q == PSR_RUN)
        else $error("Analog supply reset despite option bit");
    a_pdr_watches_ana: assert property (
        !ana_ok_s && !analog_sup_off |=> state_q == PSR_RESET)
        else $error("Analog supply loss not caught");
    a_det_fall_flag: assert property (
        det_fall && ctrl_q[`PSR_C_DET_FALL]
        |=> stat_q[`PSR_S_DET_FALL] || state_q == PSR_RESET)
        else $error("Detector fall not flagged");
    a_det_disabled: assert property (
        !ctrl_q[`PSR_C_DET_EN] |=> !$rose(stat_q[`PSR_S_DET_FALL])
        && !$rose(stat_q[`PSR_S_DET_RISE]))
        else $error("Disabled detector raised a flag");
    a_sleep_clocks: assert property (
        state_q == PSR_SLEEP |-> core_clk_en && !cpu_clk_en && core_rst_n)
        else $error("Sleep clocking wrong");
    a_stop_clocks: assert property (
        state_q == PSR_STOP |-> !core_clk_en && !pll_en
        && !internal_rc_oscillator_en && !external_crystal_oscillator_en)
        else $error("Stop left a clock running");
    a_stop_retain: assert property (
        state_q == PSR_STOP && !rst_src |=> $stable(ctrl_q) && regulator_on)
        else $error("Stop lost retained state");
    a_stop_reg_mode: assert property (
        state_q == PSR_RUN && cpu_lp_req && !rst_src
        && ctrl_q[`PSR_C_MODE_HI:`PSR_C_MODE_LO] == PSR_LP_STOP
        |=> regulator_lowpwr == $past(ctrl_q[`PSR_C_REG_LP]))
        else $error("Stop regulator mode not taken");
    a_stop_wakeup: assert property (
        state_q == PSR_STOP && stop_wake && !rst_src
        |=> state_q == PSR_RUN && cpu_clk_en)
        else $error("Stop did not wake");
    a_stby_power: assert property (
        state_q == PSR_STBY |-> !regulator_on && !pll_en
        && !internal_rc_oscillator_en && !external_crystal_oscillator_en)
        else $error("Standby left power on");
    a_stby_lost: assert property (
        state_q == PSR_STBY |=> ctrl_q == `PSR_CTRL_RST
        && mask_q == `PSR_MASK_RST)
        else $error("Registers survived standby");
    a_stby_exit: assert property (
        state_q == PSR_STBY && (wake_rise || rtc_event)
        |=> state_q == PSR_RESET ##1 !core_rst_n)
        else $error("Standby wake ignored");
    a_stby_restart: assert property (
        state_q == PSR_STBY && stby_wake && !sup_hold
        |=> stat_q[`PSR_S_STBY] && !core_rst_n)
        else $error("Standby restart not recorded");
endmodule

/* File: psr_partner.sv */
`timescale 1ns/1ps
module psr_partner import psr_pkg::*; (
    // Clock
    input  wire logic   ref_clk,
    // Supply comparators
    output logic        main_supply_ok,
    output logic        analog_supply_ok,
    output logic        detector_above,
    // Pins
    output logic        external_reset_pin_n,
    output logic        wakeup_pin,
    output logic [15:0] ext_lines,
    // On-chip sources
    output logic        independent_watchdog_rst,
    output logic        rtc_event,
    output logic        first_two_wire_port_evt,
    output logic        first_serial_port_evt,
    output logic        periph_event
);
    initial begin
        main_supply_ok = 1'b0;
        analog_supply_ok = 1'b0;
        detector_above = 1'b0;
        external_reset_pin_n = 1'b1;
        wakeup_pin = 1'b0;
        ext_lines = 16'h0000;
        {independent_watchdog_rst, rtc_event} = 2'h0;
        {first_two_wire_port_evt, first_serial_port_evt} = 2'h0;
        periph_event = 1'b0;
    end

    task automatic set_supply(input logic m, input logic a);
        @(posedge ref_clk);
        main_supply_ok <= m;
        analog_supply_ok <= a;
    endtask

    task automatic set_det(input logic v);
        @(posedge ref_clk);
        detector_above <= v;
    endtask

    // Pins stay active long enough for the synchroniser to see them
    task automatic fire(input int k);
        @(posedge ref_clk);
        case (k)
            16: rtc_event <= 1'b1;
            17: first_two_wire_port_evt <= 1'b1;
            18: first_serial_port_evt <= 1'b1;
            19: detector_above <= !detector_above;
            20: wakeup_pin <= 1'b1;
            21: external_reset_pin_n <= 1'b0;
            22: independent_watchdog_rst <= 1'b1;
            23: periph_event <= 1'b1;
            default: ext_lines <= 16'h0001 << k;
        endcase
        @(posedge ref_clk);
        {rtc_event, first_two_wire_port_evt} <= 2'h0;
        {first_serial_port_evt, independent_watchdog_rst} <= 2'h0;
        periph_event <= 1'b0;
        repeat (3) @(posedge ref_clk);
        ext_lines <= 16'h0000;
        wakeup_pin <= 1'b0;
        external_reset_pin_n <= 1'b1;
    endtask
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb import psr_pkg::*;;
    localparam int SEQ_CYC = 2000;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic        analog_sup_off = 1'b1;
    logic        cpu_lp_req = 1'b0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        main_ok, ana_ok, det_above, rst_pin_n, wake_pin;
    logic [15:0] ext_lines;
    logic        wdog, rtc_ev, twi_ev, ser_ev, per_ev;
    logic        core_rst_n, cpu_clk_en, core_clk_en, pll_en, irc_en;
    logic        xo_en, regulator_on, regulator_lowpwr, retain_en, irq;
    wire  [8:0]  outs_seen = {core_rst_n, cpu_clk_en, core_clk_en, pll_en,
                              irc_en, xo_en, regulator_on, regulator_lowpwr,
                              retain_en};
    int          num_errors = 0;
    int          checks_done = 0;
    int          exp_ctrl;
    int          cnt;
    logic        lp;
    int          stby_src[$] = '{20, 16, 21, 22};

    psr_top dut_u (
        .ref_clk(ref_clk), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .main_supply_ok(main_ok), .analog_supply_ok(ana_ok),
        .analog_sup_off(analog_sup_off), .detector_above(det_above),
        .external_reset_pin_n(rst_pin_n), .wakeup_pin(wake_pin),
        .ext_lines(ext_lines), .independent_watchdog_rst(wdog),
        .rtc_event(rtc_ev), .first_two_wire_port_evt(twi_ev),
        .first_serial_port_evt(ser_ev), .periph_event(per_ev),
        .cpu_lp_req(cpu_lp_req), .core_rst_n(core_rst_n),
        .cpu_clk_en(cpu_clk_en), .core_clk_en(core_clk_en),
        .pll_en(pll_en), .internal_rc_oscillator_en(irc_en),
        .external_crystal_oscillator_en(xo_en),
        .regulator_on(regulator_on), .regulator_lowpwr(regulator_lowpwr),
        .retain_en(retain_en), .irq(irq)
    );

    psr_partner part_u (
        .ref_clk(ref_clk), .main_supply_ok(main_ok),
        .analog_supply_ok(ana_ok), .detector_above(det_above),
        .external_reset_pin_n(rst_pin_n), .wakeup_pin(wake_pin),
        .ext_lines(ext_lines), .independent_watchdog_rst(wdog),
        .rtc_event(rtc_ev), .first_two_wire_port_evt(twi_ev),
        .first_serial_port_evt(ser_ev), .periph_event(per_ev)
    );

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic wr, input logic [3:0] adr,
                       input logic [31:0] wd, output logic [31:0] rdat);
        int   n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge ref_clk);
        avs_address <= adr;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        while (!done) begin
            @(posedge ref_clk);
            done = (avs_waitrequest === 1'b0);
            rdat = avs_readdata;
            n++;
            if (n > 50) begin
                num_errors++;
                give_verdict();
            end
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr_reg(input logic [3:0] adr, input logic [31:0] v);
        logic [31:0] d;
        bus(1'b1, adr, v, d);
    endtask

    task automatic rd_chk(input string what, input logic [3:0] adr,
                          input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, adr, 32'h0000_0000, d);
        chk(what, d, exp);
    endtask

    // Counts cycles until cpu clock (sel 0) or core reset (sel 1) rises
    task automatic wait_hi(input int sel, input int lim, output int n);
        n = 0;
        while ((sel == 0 ? cpu_clk_en : core_rst_n) !== 1'b1) begin
            @(negedge ref_clk);
            n++;
            if (n > lim) begin
                num_errors++;
                give_verdict();
            end
        end
    endtask

    task automatic lp_enter();
        @(posedge ref_clk);
        cpu_lp_req <= 1'b1;
        @(posedge ref_clk);
        cpu_lp_req <= 1'b0;
        @(negedge ref_clk);
    endtask

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        void'($urandom(32'h2C5E));
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (100) @(negedge ref_clk);
        chk("held in reset", outs_seen, 9'h07C);
        part_u.set_supply(1'b1, 1'b0);
        wait_hi(1, SEQ_CYC + 100, cnt);
        chk("reset stretch", cnt >= SEQ_CYC, 1'b1);
        chk("run outputs", outs_seen, 9'h1FC);
        rd_chk("state", 4'hC, 32'h11);
        rd_chk("ctrl", 4'h0, 32'h00);
        rd_chk("mask", 4'h8, 32'h00);
        part_u.set_supply(1'b1, 1'b1);
        // Let the analog flag pass the synchroniser first
        repeat (3) @(posedge ref_clk);
        analog_sup_off <= 1'b0;
        $display("power up test done");

        wr_reg(4'h0, 32'h00);
        wr_reg(4'h8, 32'h1F);
        lp_enter();
        chk("sleep outputs", outs_seen, 9'h17C);
        part_u.fire(23);
        wait_hi(0, 20, cnt);
        chk("sleep irq", irq, 1'b1);
        rd_chk("sleep wake", 4'h4, 32'h08);
        wr_reg(4'h4, 32'h08);
        @(negedge ref_clk);
        chk("irq cleared", irq, 1'b0);
        $display("sleep test done");

        wr_reg(4'h0, 32'h06);
        part_u.set_det(1'b1);
        repeat (8) @(negedge ref_clk);
        rd_chk("detector off", 4'h4, 32'h00);
        wr_reg(4'h0, 32'h07);
        part_u.set_det(1'b0);
        repeat (8) @(negedge ref_clk);
        rd_chk("fall", 4'h4, 32'h01);
        chk("fall irq", irq, 1'b1);
        part_u.set_det(1'b1);
        repeat (8) @(negedge ref_clk);
        rd_chk("rise", 4'h4, 32'h03);
        wr_reg(4'h4, 32'h03);
        rd_chk("cleared", 4'h4, 32'h00);
        $display("detector test done");

        for (int k = 0; k < 20; k++) begin
            lp = 1'($urandom);
            exp_ctrl = 32'h17 | {lp, 3'h0};
            wr_reg(4'h0, exp_ctrl);
            lp_enter();
            chk("stop outputs", outs_seen, 9'h105 | {lp, 1'b0});
            part_u.fire(k);
            wait_hi(0, 20, cnt);
            rd_chk("ctrl kept", 4'h0, exp_ctrl);
            rd_chk("stop wake", 4'h4, k == 19 ? 32'h05 : 32'h04);
            wr_reg(4'h4, 32'h1F);
        end
        $display("stop test done");

        foreach (stby_src[i]) begin
            wr_reg(4'h8, 32'h1F & $urandom | 32'h01);
            wr_reg(4'h0, 32'h27);
            lp_enter();
            chk("standby outputs", outs_seen, 9'h000);
            part_u.fire(stby_src[i]);
            wait_hi(1, SEQ_CYC + 100, cnt);
            // Pin pulse inside fire takes a few cycles of the stretch
            chk("restart stretch", cnt > SEQ_CYC - 10, 1'b1);
            rd_chk("from standby", 4'h4, 32'h10);
            rd_chk("ctrl lost", 4'h0, 32'h00);
            rd_chk("mask lost", 4'h8, 32'h00);
            chk("standby irq", irq, 1'b0);
            wr_reg(4'h4, 32'h10);
        end
        $display("standby test done");

        part_u.set_supply(1'b0, 1'b1);
        repeat (6) @(negedge ref_clk);
        chk("main low", core_rst_n, 1'b0);
        part_u.set_supply(1'b1, 1'b1);
        wait_hi(1, SEQ_CYC + 100, cnt);
        chk("restart", cnt >= SEQ_CYC, 1'b1);
        part_u.set_supply(1'b1, 1'b0);
        repeat (6) @(negedge ref_clk);
        chk("analog low", core_rst_n, 1'b0);
        part_u.set_supply(1'b1, 1'b1);
        wait_hi(1, SEQ_CYC + 100, cnt);
        @(posedge ref_clk);
        analog_sup_off <= 1'b1;
        part_u.set_supply(1'b1, 1'b0);
        repeat (20) @(negedge ref_clk);
        chk("analog ignored", core_rst_n, 1'b1);
        rd_chk("state after", 4'hC, 32'h11);
        $display("supply test done");
        give_verdict();
    end
endmodule
